// File: pcrb_map.svh
`ifndef PCRB_MAP_SVH
`define PCRB_MAP_SVH

// register byte addresses, 19-bit host address
`define PCRB_A_TX_CLK_DP 19'h00004
`define PCRB_A_TX_LANE_CLK 19'h00005
`define PCRB_A_RX_CLK_DP 19'h00006
`define PCRB_A_RX_GBX_CLK 19'h00007
`define PCRB_A_TX_DESKEW 19'h00009
`define PCRB_A_IDLE_LO 19'h0001c
`define PCRB_A_IDLE_HI 19'h00020
`define PCRB_A_IDLE_TOP 19'h00024
`define PCRB_A_BITCNT_LO 19'h00034
`define PCRB_A_BITCNT_MID 19'h00035
`define PCRB_A_BITCNT_HI 19'h00036
`define PCRB_A_FIFO_LAT 19'h00037
`define PCRB_A_DCC_CTRL 19'h00038
`define PCRB_A_DCC_FSM 19'h0003c
`define PCRB_A_CORE_LO 19'h00080
`define PCRB_A_CORE_HI 19'h00081
`define PCRB_A_ATTR_DATA_LO 19'h00084
`define PCRB_A_ATTR_DATA_HI 19'h00085
`define PCRB_A_ATTR_CODE_LO 19'h00086
`define PCRB_A_ATTR_CODE_HI 19'h00087
`define PCRB_A_ATTR_RET_LO 19'h00088
`define PCRB_A_ATTR_RET_HI 19'h00089
`define PCRB_A_ATTR_SENT 19'h0008a
`define PCRB_A_ATTR_BUSY 19'h0008b
`define PCRB_A_ATTR_LOAD 19'h00090
`define PCRB_A_RELOAD 19'h00091
`define PCRB_A_LOAD_CAL 19'h00095
`define PCRB_A_REFMAP_A 19'h000ec
`define PCRB_A_REFMAP_B 19'h000ee
`define PCRB_A_REFMAP_C 19'h000ef
`define PCRB_A_MODE_OP0 19'h00200
`define PCRB_A_MODE_OP3 19'h00203
`define PCRB_A_PHYS_CHAN 19'h00204
`define PCRB_A_MODE_DONE 19'h00207
`define PCRB_A_IDENT0 19'h40000
`define PCRB_A_IDENT3 19'h40003
`define PCRB_A_STAT_PRES 19'h40004
`define PCRB_A_CTRL_PRES 19'h40005
`define PCRB_A_CHAN_COUNT 19'h40010
`define PCRB_A_CHAN_INDEX 19'h40011
`define PCRB_A_DIR_MODE 19'h40012
`define PCRB_A_LOCK_STAT 19'h40080
`define PCRB_A_RDY_STAT 19'h40081
`define PCRB_A_XFER_STAT 19'h40082
`define PCRB_A_RST_OVR 19'h400e2
`define PCRB_A_STREAM_CTRL 19'h40140
`define PCRB_A_STREAM_STAT 19'h40141
`define PCRB_A_CFG_LOAD_REQ 19'h40143
`define PCRB_A_CFG_LOAD_STAT 19'h40144

// field positions, widths and values
`define PCRB_GO_BIT 7
`define PCRB_SEL_MSB 2
`define PCRB_OVR_SEL_LSB 4
`define PCRB_CAL_BIT 5
`define PCRB_DONE_BIT 7
`define PCRB_REFSEL_MAX 4'h8
`define PCRB_DUPLEX 2'h3
`define PCRB_BITCNT_WIDTH 13

// reset values
`define PCRB_RST_BYTE 8'h00
`define PCRB_RST_REFMAP 8'h00

`endif

// File: pcrb_pkg.sv
package pcrb_pkg;

    // attribute mailbox sequencer
    typedef enum logic [3:0] {
        PCRB_MB_IDLE = 4'h1,
        PCRB_MB_SEND = 4'h2,
        PCRB_MB_WAIT = 4'h4,
        PCRB_MB_DONE = 4'h8
    } pcrb_mb_e;

    typedef logic [7:0] pcrb_byte_t;

endpackage

// File: pcrb_trigger.sv
`timescale 1ns/100ps
// one go-bit handshake: pulse out on request, busy until the far end finishes
module pcrb_trigger (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic go_i,
    input wire logic done_i,
    output logic start_o,
    output logic busy_o
);
    typedef struct packed {
        logic start;
        logic busy;
    } pcrb_trig_s;

    pcrb_trig_s s_q;
    pcrb_trig_s s_d;

    // done clears busy; a go that arrives while busy is dropped, even in the done cycle
    always_comb begin
        s_d = s_q;
        s_d.start = 1'b0;
        if (s_q.busy && done_i) begin
            s_d.busy = 1'b0;
        end
        if (go_i && !s_q.busy) begin
            s_d.start = 1'b1;
            s_d.busy = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign start_o = s_q.start;
    assign busy_o = s_q.busy;
endmodule // pcrb_trigger

// File: pcrb_reset_mux.sv
`timescale 1ns/100ps
// per-reset source select: controller or software bit
module pcrb_reset_mux (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ctrl_rst_i,
    input wire logic sw_val_i,
    input wire logic sw_sel_i,
    output logic rst_o
);
    typedef struct packed {
        logic rst;
    } pcrb_rmux_s;

    pcrb_rmux_s s_q;
    pcrb_rmux_s s_d;

    // registered so the outgoing reset is glitch free
    always_comb begin
        s_d.rst = sw_sel_i ? sw_val_i : ctrl_rst_i;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s_q <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign rst_o = s_q.rst;
endmodule // pcrb_reset_mux

// File: pcrb_channel_regs.sv
`timescale 1ns/100ps
`include "pcrb_map.svh"

module pcrb_channel_regs #(
    parameter logic [31:0] INSTANCE_ID = 32'h5a5a_0001, // arbitrary value
    parameter logic [7:0] CHANNEL_COUNT = 8'h01,
    parameter logic [7:0] CHANNEL_INDEX = 8'h00,
    parameter logic [7:0] PHYS_CHANNEL = 8'h00,
    parameter logic STATUS_PRESENT = 1'b1,
    parameter logic CONTROL_PRESENT = 1'b1
) (
    input wire logic clk_i,
    input wire logic srst_i,
    // host register port, byte wide
    input wire logic [18:0] host_addr_i,
    input wire logic host_read_i,
    input wire logic host_write_i,
    input wire logic [7:0] host_wdata_i,
    output logic [7:0] host_rdata_o,
    output logic host_rvalid_o,
    output logic host_waitrequest_o,
    // live channel status
    input wire logic rx_cdr_data_lock_i,
    input wire logic tx_ready_i,
    input wire logic rx_ready_i,
    input wire logic tx_xfer_ready_i,
    input wire logic rx_xfer_ready_i,
    input wire logic [1:0] tx_deskew_state_i,
    input wire logic tx_deskew_aligned_i,
    // reset controller requests
    input wire logic [3:0] ctrl_reset_i,
    output logic [3:0] datapath_reset_o,
    // profile streamer and stored configuration load
    output logic stream_start_o,
    output logic [2:0] stream_profile_o,
    input wire logic stream_done_i,
    output logic cfg_load_start_o,
    output logic [2:0] cfg_load_sel_o,
    input wire logic cfg_load_finish_i,
    input wire logic cfg_load_timeout_i,
    // attribute mailbox to analog channel
    output logic attr_send_o,
    output logic [31:0] attr_word_o,
    input wire logic attr_ack_i,
    input wire logic attr_done_i,
    input wire logic [15:0] attr_return_i,
    // settings reload and calibration
    output logic reload_start_o,
    output logic reload_cal_o,
    // mode and analog reset operation
    output logic mode_op_start_o,
    output logic [31:0] mode_op_word_o,
    input wire logic mode_op_done_i,
    input wire logic mode_op_fail_i,
    // datapath configuration outward
    output logic [7:0] tx_clk_dp_o,
    output logic [7:0] rx_clk_dp_o,
    output logic [15:0] bit_count_wrap_o,
    output logic [23:0] refclk_map_o
);

    typedef struct packed {
        logic [7:0] rdata;
        logic rvalid;
        logic [7:0] tx_clk_dp;
        logic [7:0] tx_lane_clk;
        logic [7:0] rx_clk_dp;
        logic [7:0] rx_gbx_clk;
        logic [7:0] deskew_ctrl;
        logic [7:0] idle_lo;
        logic [7:0] idle_hi;
        logic [7:0] idle_top;
        logic [7:0] bitcnt_lo;
        logic [7:0] bitcnt_mid;
        logic [7:0] bitcnt_hi;
        logic [7:0] fifo_lat;
        logic [7:0] dcc_ctrl;
        logic [7:0] dcc_fsm;
        logic [15:0] core_ctrl;
        logic [31:0] attr_word;
        logic [15:0] attr_ret;
        logic attr_sent;
        logic attr_busy;
        logic attr_send;
        pcrb_pkg::pcrb_mb_e mb;
        logic reload;
        logic [7:0] load_cal;
        logic [23:0] refmap;
        logic [31:0] mode_word;
        logic mode_start;
        logic mode_busy;
        logic mode_done;
        logic mode_fail;
        logic [7:0] rst_ovr;
        logic [2:0] stream_sel;
        logic [2:0] cfg_sel;
        logic cfg_finish;
        logic cfg_timeout;
    } pcrb_regs_s;

    pcrb_regs_s r_q;
    pcrb_regs_s r_d;

    logic stream_go;
    logic stream_busy;
    logic cfg_go;
    logic cfg_busy;
    logic is_chan0;
    logic [1:0] mode_idx;

    assign is_chan0 = (CHANNEL_INDEX == 8'h00);
    assign mode_idx = host_addr_i[1:0];

    // go bits are decoded straight from the write, never stored
    assign stream_go = host_write_i && host_addr_i == `PCRB_A_STREAM_CTRL
        && host_wdata_i[`PCRB_GO_BIT];
    assign cfg_go = is_chan0 && host_write_i && host_addr_i == `PCRB_A_CFG_LOAD_REQ
        && host_wdata_i[`PCRB_GO_BIT];

    pcrb_trigger u_stream (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .go_i(stream_go),
        .done_i(stream_done_i),
        .start_o(stream_start_o),
        .busy_o(stream_busy)
    );

    pcrb_trigger u_cfg_load (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .go_i(cfg_go),
        .done_i(cfg_load_finish_i | cfg_load_timeout_i),
        .start_o(cfg_load_start_o),
        .busy_o(cfg_busy)
    );

    // one mux per datapath reset
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_rst
            pcrb_reset_mux u_mux (
                .clk_i(clk_i),
                .srst_i(srst_i),
                .ctrl_rst_i(ctrl_reset_i[gi]),
                .sw_val_i(r_q.rst_ovr[gi]),
                .sw_sel_i(r_q.rst_ovr[gi + `PCRB_OVR_SEL_LSB]),
                .rst_o(datapath_reset_o[gi])
            );
        end
    endgenerate

    // register decode, mailbox sequencer and read mux
    always_comb begin
        r_d = r_q;
        r_d.rvalid = host_read_i;
        r_d.attr_send = 1'b0;
        r_d.reload = 1'b0;
        r_d.mode_start = 1'b0;

        // sticky load results; set wins, cleared by a new request
        if (cfg_go) begin
            r_d.cfg_finish = 1'b0;
            r_d.cfg_timeout = 1'b0;
        end
        if (cfg_load_finish_i) begin
            r_d.cfg_finish = 1'b1;
        end
        if (cfg_load_timeout_i) begin
            r_d.cfg_timeout = 1'b1;
        end

        if (host_write_i) begin
            case (host_addr_i)
                `PCRB_A_TX_CLK_DP: r_d.tx_clk_dp = host_wdata_i;
                `PCRB_A_TX_LANE_CLK: r_d.tx_lane_clk = host_wdata_i;
                `PCRB_A_RX_CLK_DP: r_d.rx_clk_dp = host_wdata_i;
                `PCRB_A_RX_GBX_CLK: r_d.rx_gbx_clk = host_wdata_i;
                `PCRB_A_TX_DESKEW: r_d.deskew_ctrl = host_wdata_i;
                `PCRB_A_IDLE_LO: r_d.idle_lo = host_wdata_i;
                `PCRB_A_IDLE_HI: r_d.idle_hi = host_wdata_i;
                `PCRB_A_IDLE_TOP: r_d.idle_top = host_wdata_i;
                `PCRB_A_BITCNT_LO: r_d.bitcnt_lo = host_wdata_i;
                `PCRB_A_BITCNT_MID: r_d.bitcnt_mid = host_wdata_i;
                `PCRB_A_BITCNT_HI: r_d.bitcnt_hi = host_wdata_i;
                `PCRB_A_FIFO_LAT: r_d.fifo_lat = host_wdata_i;
                `PCRB_A_DCC_CTRL: r_d.dcc_ctrl = host_wdata_i;
                `PCRB_A_DCC_FSM: r_d.dcc_fsm = host_wdata_i;
                `PCRB_A_CORE_LO: r_d.core_ctrl[7:0] = host_wdata_i;
                `PCRB_A_CORE_HI: r_d.core_ctrl[15:8] = host_wdata_i;
                `PCRB_A_ATTR_DATA_LO: r_d.attr_word[7:0] = host_wdata_i;
                `PCRB_A_ATTR_DATA_HI: r_d.attr_word[15:8] = host_wdata_i;
                `PCRB_A_ATTR_CODE_LO: r_d.attr_word[23:16] = host_wdata_i;
                `PCRB_A_ATTR_CODE_HI: r_d.attr_word[31:24] = host_wdata_i;
                // writing one to bit 7 clears the sent flag
                `PCRB_A_ATTR_SENT: begin
                    if (host_wdata_i[`PCRB_DONE_BIT]) begin
                        r_d.attr_sent = 1'b0;
                    end
                end
                `PCRB_A_ATTR_LOAD: begin
                    if (host_wdata_i[0] && r_q.mb == pcrb_pkg::PCRB_MB_IDLE) begin
                        r_d.mb = pcrb_pkg::PCRB_MB_SEND;
                        r_d.attr_send = 1'b1;
                        r_d.attr_busy = 1'b1;
                        r_d.attr_sent = 1'b0;
                    end
                end
                `PCRB_A_RELOAD: r_d.reload = host_wdata_i[0];
                `PCRB_A_LOAD_CAL: r_d.load_cal = host_wdata_i;
                `PCRB_A_REFMAP_A: r_d.refmap[7:0] = host_wdata_i;
                `PCRB_A_REFMAP_B: r_d.refmap[15:8] = host_wdata_i;
                `PCRB_A_REFMAP_C: r_d.refmap[23:16] = host_wdata_i;
                `PCRB_A_RST_OVR: r_d.rst_ovr = host_wdata_i;
                `PCRB_A_STREAM_CTRL: r_d.stream_sel = host_wdata_i[`PCRB_SEL_MSB:0];
                `PCRB_A_CFG_LOAD_REQ: begin
                    if (is_chan0) begin
                        r_d.cfg_sel = host_wdata_i[`PCRB_SEL_MSB:0];
                    end
                end
                default: begin
                    // last of the four mode bytes launches the operation
                    if (host_addr_i >= `PCRB_A_MODE_OP0 && host_addr_i <= `PCRB_A_MODE_OP3) begin
                        r_d.mode_word[mode_idx * 8 +: 8] = host_wdata_i;
                        if (host_addr_i == `PCRB_A_MODE_OP3) begin
                            r_d.mode_start = 1'b1;
                            r_d.mode_busy = 1'b1;
                            r_d.mode_done = 1'b0;
                        end
                    end
                end
            endcase
        end

        // mode operation completion; done sticky until next launch, fail held until next completion
        if (r_q.mode_busy && mode_op_done_i) begin
            r_d.mode_busy = 1'b0;
            r_d.mode_done = 1'b1;
            r_d.mode_fail = mode_op_fail_i;
        end

        // attribute mailbox: send, wait for analog, latch return
        case (r_q.mb)
            pcrb_pkg::PCRB_MB_IDLE: begin
            end
            pcrb_pkg::PCRB_MB_SEND: begin
                if (attr_ack_i) begin
                    r_d.attr_sent = 1'b1;
                    r_d.mb = pcrb_pkg::PCRB_MB_WAIT;
                end
            end
            pcrb_pkg::PCRB_MB_WAIT: begin
                if (attr_done_i) begin
                    r_d.attr_ret = attr_return_i;
                    r_d.mb = pcrb_pkg::PCRB_MB_DONE;
                end
            end
            pcrb_pkg::PCRB_MB_DONE: begin
                r_d.attr_busy = 1'b0;
                r_d.mb = pcrb_pkg::PCRB_MB_IDLE;
            end
            default: r_d.mb = pcrb_pkg::PCRB_MB_IDLE;
        endcase

        // read mux, unmapped bytes read zero
        r_d.rdata = `PCRB_RST_BYTE;
        if (host_read_i) begin
            case (host_addr_i)
                `PCRB_A_TX_CLK_DP: r_d.rdata = r_q.tx_clk_dp;
                `PCRB_A_TX_LANE_CLK: r_d.rdata = r_q.tx_lane_clk;
                `PCRB_A_RX_CLK_DP: r_d.rdata = r_q.rx_clk_dp;
                `PCRB_A_RX_GBX_CLK: r_d.rdata = r_q.rx_gbx_clk;
                `PCRB_A_TX_DESKEW: r_d.rdata = {r_q.deskew_ctrl[7:5], tx_deskew_aligned_i,
                    tx_deskew_state_i, r_q.deskew_ctrl[1:0]};
                `PCRB_A_IDLE_LO: r_d.rdata = r_q.idle_lo;
                `PCRB_A_IDLE_HI: r_d.rdata = r_q.idle_hi;
                `PCRB_A_IDLE_TOP: r_d.rdata = r_q.idle_top;
                `PCRB_A_BITCNT_LO: r_d.rdata = r_q.bitcnt_lo;
                `PCRB_A_BITCNT_MID: r_d.rdata = r_q.bitcnt_mid;
                `PCRB_A_BITCNT_HI: r_d.rdata = r_q.bitcnt_hi;
                `PCRB_A_FIFO_LAT: r_d.rdata = r_q.fifo_lat;
                `PCRB_A_DCC_CTRL: r_d.rdata = r_q.dcc_ctrl;
                `PCRB_A_DCC_FSM: r_d.rdata = r_q.dcc_fsm;
                `PCRB_A_CORE_LO: r_d.rdata = r_q.core_ctrl[7:0];
                `PCRB_A_CORE_HI: r_d.rdata = r_q.core_ctrl[15:8];
                `PCRB_A_ATTR_DATA_LO: r_d.rdata = r_q.attr_word[7:0];
                `PCRB_A_ATTR_DATA_HI: r_d.rdata = r_q.attr_word[15:8];
                `PCRB_A_ATTR_CODE_LO: r_d.rdata = r_q.attr_word[23:16];
                `PCRB_A_ATTR_CODE_HI: r_d.rdata = r_q.attr_word[31:24];
                `PCRB_A_ATTR_RET_LO: r_d.rdata = r_q.attr_ret[7:0];
                `PCRB_A_ATTR_RET_HI: r_d.rdata = r_q.attr_ret[15:8];
                `PCRB_A_ATTR_SENT: r_d.rdata = {r_q.attr_sent, 7'h00};
                `PCRB_A_ATTR_BUSY: r_d.rdata = {7'h00, r_q.attr_busy};
                `PCRB_A_LOAD_CAL: r_d.rdata = r_q.load_cal;
                `PCRB_A_REFMAP_A: r_d.rdata = r_q.refmap[7:0];
                `PCRB_A_REFMAP_B: r_d.rdata = r_q.refmap[15:8];
                `PCRB_A_REFMAP_C: r_d.rdata = r_q.refmap[23:16];
                `PCRB_A_PHYS_CHAN: r_d.rdata = PHYS_CHANNEL;
                `PCRB_A_MODE_DONE: r_d.rdata = {r_q.mode_done, 6'h00, r_q.mode_fail};
                `PCRB_A_STAT_PRES: r_d.rdata = {7'h00, STATUS_PRESENT};
                `PCRB_A_CTRL_PRES: r_d.rdata = {7'h00, CONTROL_PRESENT};
                `PCRB_A_CHAN_COUNT: r_d.rdata = CHANNEL_COUNT;
                `PCRB_A_CHAN_INDEX: r_d.rdata = CHANNEL_INDEX;
                `PCRB_A_DIR_MODE: r_d.rdata = {6'h00, `PCRB_DUPLEX};
                `PCRB_A_LOCK_STAT: r_d.rdata = {7'h00, rx_cdr_data_lock_i};
                `PCRB_A_RDY_STAT: r_d.rdata = {6'h00, rx_ready_i, tx_ready_i};
                `PCRB_A_XFER_STAT: r_d.rdata = {6'h00, rx_xfer_ready_i, tx_xfer_ready_i};
                `PCRB_A_RST_OVR: r_d.rdata = r_q.rst_ovr;
                `PCRB_A_STREAM_CTRL: r_d.rdata = {5'h00, r_q.stream_sel};
                `PCRB_A_STREAM_STAT: r_d.rdata = {7'h00, stream_busy};
                `PCRB_A_CFG_LOAD_REQ: r_d.rdata = is_chan0 ? {5'h00, r_q.cfg_sel} : 8'h00;
                `PCRB_A_CFG_LOAD_STAT: r_d.rdata = is_chan0 ? {5'h00, cfg_busy,
                    r_q.cfg_timeout, r_q.cfg_finish} : 8'h00;
                default: begin
                    if (host_addr_i >= `PCRB_A_IDENT0 && host_addr_i <= `PCRB_A_IDENT3) begin
                        r_d.rdata = INSTANCE_ID[mode_idx * 8 +: 8];
                    end else if (host_addr_i >= `PCRB_A_MODE_OP0
                            && host_addr_i <= `PCRB_A_MODE_OP3) begin
                        r_d.rdata = r_q.mode_word[mode_idx * 8 +: 8];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r_q <= '0;
            r_q.mb <= pcrb_pkg::PCRB_MB_IDLE;
            r_q.refmap <= {3{`PCRB_RST_REFMAP}};
        end else begin
            r_q <= r_d;
        end
    end

    // outputs from flops, waitrequest tied low
    assign host_rdata_o = r_q.rdata;
    assign host_rvalid_o = r_q.rvalid;
    assign host_waitrequest_o = 1'b0;
    assign stream_profile_o = r_q.stream_sel;
    assign cfg_load_sel_o = r_q.cfg_sel;
    assign attr_send_o = r_q.attr_send;
    assign attr_word_o = r_q.attr_word;
    assign reload_start_o = r_q.reload;
    assign reload_cal_o = r_q.load_cal[`PCRB_CAL_BIT];
    assign mode_op_start_o = r_q.mode_start;
    assign mode_op_word_o = r_q.mode_word;
    assign tx_clk_dp_o = r_q.tx_clk_dp;
    assign rx_clk_dp_o = r_q.rx_clk_dp;
    assign bit_count_wrap_o = {r_q.bitcnt_hi[0], r_q.bitcnt_mid, r_q.bitcnt_lo[7:4], 3'h0};
    assign refclk_map_o = r_q.refmap;

endmodule // pcrb_channel_regs

// File: pcrb_channel_regs_properties.sv
`timescale 1ns/100ps
`include "pcrb_map.svh"
module pcrb_channel_regs_properties (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [18:0] host_addr_i,
    input wire logic host_read_i,
    input wire logic host_write_i,
    input wire logic [7:0] host_wdata_i,
    input wire logic host_rvalid_o,
    input wire logic host_waitrequest_o,
    input wire logic stream_start_o,
    input wire logic attr_send_o,
    input wire logic reload_start_o,
    input wire logic reload_cal_o,
    input wire logic mode_op_start_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // a host write to one register byte
    sequence s_wr(logic [18:0] a);
        host_write_i && host_addr_i == a;
    endsequence
    a_read_answer: assert property (host_read_i |=> host_rvalid_o) else $error("no read answer");
    a_no_stray: assert property (!host_read_i |=> !host_rvalid_o) else $error("stray rvalid");
    a_never_stall: assert property (!host_waitrequest_o) else $error("port stalled");
    a_attr_cause: assert property (attr_send_o |-> $past(host_write_i && host_addr_i ==
        `PCRB_A_ATTR_LOAD && host_wdata_i[0])) else $error("send without load");
    a_stream_cause: assert property (stream_start_o |-> $past(host_write_i && host_addr_i ==
        `PCRB_A_STREAM_CTRL && host_wdata_i[7])) else $error("stray stream start");
    a_reload_go: assert property (s_wr(`PCRB_A_RELOAD) ##0 host_wdata_i[0] |=> reload_start_o)
        else $error("reload not started");
    a_mode_go: assert property (s_wr(`PCRB_A_MODE_OP3) |=> mode_op_start_o)
        else $error("mode op not started");
    a_cal_level: assert property (s_wr(`PCRB_A_LOAD_CAL) |=> reload_cal_o == $past(host_wdata_i[5]))
        else $error("cal bit wrong");
endmodule // pcrb_channel_regs_properties

// File: pcrb_analog_model.sv
`timescale 1ns/100ps
// far end: answers mailbox, mode, stream and load requests after fixed delays
module pcrb_analog_model (
    input wire logic clk_i,
    input wire logic reject_i,
    input wire logic attr_send_o,
    input wire logic [31:0] attr_word_o,
    input wire logic mode_op_start_o,
    input wire logic stream_start_o,
    input wire logic cfg_load_start_o,
    output logic attr_ack_i = 1'b0,
    output logic attr_done_i = 1'b0,
    output logic [15:0] attr_return_i = 16'hffff,
    output logic mode_op_done_i = 1'b0,
    output logic mode_op_fail_i = 1'b0,
    output logic stream_done_i = 1'b0,
    output logic cfg_load_finish_i = 1'b0,
    output logic cfg_load_timeout_i = 1'b0
);
    logic str_q, cfg_q;
    // mailbox; return is only meaningful with done, so it flips afterwards
    always @(posedge clk_i) begin
        if (attr_send_o) begin
            repeat (2) @(posedge clk_i);
            #1 attr_ack_i = 1'b1;
            @(posedge clk_i);
            #1 attr_ack_i = 1'b0;
            @(posedge clk_i);
            #1 attr_done_i = 1'b1;
            attr_return_i = reject_i ? 16'h0000 : attr_word_o[31:16];
            @(posedge clk_i);
            #1 attr_done_i = 1'b0;
            attr_return_i = ~attr_return_i;
        end
    end
    // mode operation fails when told to reject
    always @(posedge clk_i) begin
        if (mode_op_start_o) begin
            repeat (3) @(posedge clk_i);
            #1 {mode_op_done_i, mode_op_fail_i} = {1'b1, reject_i};
            @(posedge clk_i);
            #1 {mode_op_done_i, mode_op_fail_i} = 2'b01;
        end
    end
    // streaming and stored load finish alike
    always @(posedge clk_i) begin
        if (stream_start_o || cfg_load_start_o) begin
            {str_q, cfg_q} = {stream_start_o, cfg_load_start_o};
            repeat (3) @(posedge clk_i);
            #1 {stream_done_i, cfg_load_finish_i} = {str_q, cfg_q};
            @(posedge clk_i);
            #1 {stream_done_i, cfg_load_finish_i} = 2'b00;
        end
    end
endmodule // pcrb_analog_model

// File: pcrb_channel_regs_tb.sv
`timescale 1ns/100ps
`include "pcrb_map.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected at %0t: %h vs %h", $time, (g), (e)); end end
module pcrb_channel_regs_tb;
    localparam logic [31:0] ID_P = 32'hc3a5_1e70; // arbitrary value
    logic clk_i = 1'b0, srst_i = 1'b1, host_read_i = 1'b0, host_write_i = 1'b0;
    logic [18:0] host_addr_i = 19'h00000;
    logic [7:0] host_wdata_i = 8'h00, host_rdata_o, tx_clk_dp_o, rx_clk_dp_o, rdat;
    logic host_rvalid_o, host_waitrequest_o, tx_deskew_aligned_i, reject_i;
    logic rx_cdr_data_lock_i, tx_ready_i, rx_ready_i, tx_xfer_ready_i, rx_xfer_ready_i;
    logic [1:0] tx_deskew_state_i, b;
    logic [3:0] ctrl_reset_i = 4'h3, datapath_reset_o;
    logic stream_start_o, cfg_load_start_o, attr_send_o, reload_start_o, reload_cal_o;
    logic mode_op_start_o, stream_done_i, cfg_load_finish_i, cfg_load_timeout_i;
    logic attr_ack_i, attr_done_i, mode_op_done_i, mode_op_fail_i;
    logic [2:0] stream_profile_o, cfg_load_sel_o;
    logic [31:0] attr_word_o, mode_op_word_o, mbw;
    logic [15:0] bit_count_wrap_o, attr_return_i;
    logic [23:0] refclk_map_o;
    logic [7:0] ovr [4] = '{8'h00, 8'h5a, 8'hf0, 8'h0f};
    int err_count = 0, check_count = 0, cyc = 0;
    pcrb_channel_regs #(.INSTANCE_ID(ID_P), .CHANNEL_COUNT(8'h04)) uut (.*);
    pcrb_analog_model u_far (.*);
    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // host side uses mapped bytes only, one strobe held over its taking edge
    task automatic wr(input logic [18:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1 {host_addr_i, host_wdata_i, host_write_i} = {a, d, 1'b1};
        @(posedge clk_i);
        #1 host_write_i = 1'b0;
    endtask
    task automatic rd(input logic [18:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk_i);
        #1 {host_addr_i, host_read_i} = {a, 1'b1};
        @(posedge clk_i);
        #1 host_read_i = 1'b0;
        rdat = host_rdata_o;
        `CHK(host_rvalid_o, 1'b1)
        `CHK(rdat & m, e)
    endtask
    // go bit, busy while running, status once the far end is done
    task automatic go(input logic [18:0] a, input logic [7:0] d, input logic [7:0] bm,
                      input logic [7:0] em, input logic [7:0] ee);
        wr(a, d);
        @(posedge clk_i);
        rd(a + 19'h1, bm, bm);
        repeat (6) @(posedge clk_i);
        rd(a + 19'h1, em, ee);
    endtask
    initial forever #2 clk_i = ~clk_i;
    // a hang counts as a mismatch
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        {rx_cdr_data_lock_i, tx_ready_i, rx_ready_i, tx_xfer_ready_i, rx_xfer_ready_i} = 5'h00;
        {tx_deskew_state_i, tx_deskew_aligned_i, reject_i} = 4'h0;
        repeat (16) @(posedge clk_i);
        #1 srst_i = 1'b0;
        rd(`PCRB_A_TX_CLK_DP, 8'hff, `PCRB_RST_BYTE);
        for (int i = 0; i < 4; i++) rd(19'(`PCRB_A_IDENT0 + i), 8'hff, ID_P[8*i +: 8]);
        rd(`PCRB_A_STAT_PRES, 8'h01, 8'h01);
        rd(`PCRB_A_CTRL_PRES, 8'h01, 8'h01);
        rd(`PCRB_A_CHAN_COUNT, 8'hff, 8'h04);
        rd(`PCRB_A_CHAN_INDEX, 8'hff, 8'h00);
        rd(`PCRB_A_DIR_MODE, 8'h03, `PCRB_DUPLEX);
        // live status and deskew bytes follow four input patterns
        for (int i = 0; i < 4; i++) begin
            b = 2'(i);
            {rx_cdr_data_lock_i, tx_ready_i, rx_ready_i} = {b[0], b[1], ~b[0]};
            {tx_xfer_ready_i, rx_xfer_ready_i, tx_deskew_state_i} = {^b, ~b[1], b};
            tx_deskew_aligned_i = b[1];
            rd(`PCRB_A_LOCK_STAT, 8'h01, {7'h00, b[0]});
            rd(`PCRB_A_RDY_STAT, 8'h03, {6'h00, ~b[0], b[1]});
            rd(`PCRB_A_XFER_STAT, 8'h03, {6'h00, ~b[1], ^b});
            rd(`PCRB_A_TX_DESKEW, 8'h1c, {3'h0, b[1], b, 2'h0});
        end
        foreach (ovr[k]) begin
            wr(`PCRB_A_RST_OVR, ovr[k]);
            rd(`PCRB_A_RST_OVR, 8'hff, ovr[k]);
            `CHK(datapath_reset_o, (ovr[k][7:4] & ovr[k][3:0]) | (~ovr[k][7:4] & ctrl_reset_i))
        end
        go(`PCRB_A_STREAM_CTRL, 8'h85, 8'h01, 8'h01, 8'h00);
        `CHK(stream_profile_o, 3'h5)
        go(`PCRB_A_CFG_LOAD_REQ, 8'h83, 8'h04, 8'h07, 8'h01);
        `CHK(cfg_load_sel_o, 3'h3)
        // second mailbox pass is rejected by the far end
        for (int k = 0; k < 2; k++) begin
            reject_i = k[0];
            mbw = {8'h00, 8'(k + 1), 8'h12, 8'h34};
            for (int j = 0; j < 4; j++) wr(19'(`PCRB_A_ATTR_DATA_LO + j), mbw[8*j +: 8]);
            wr(`PCRB_A_ATTR_LOAD, 8'h01);
            rd(`PCRB_A_ATTR_SENT, 8'h80, 8'h00);
            rd(`PCRB_A_ATTR_BUSY, 8'h01, 8'h01);
            `CHK(attr_word_o, mbw)
            repeat (20) if (rdat[0] === 1'b1) rd(`PCRB_A_ATTR_BUSY, 8'h00, 8'h00);
            `CHK(rdat[0], 1'b0)
            rd(`PCRB_A_ATTR_SENT, 8'h80, 8'h80);
            rd(`PCRB_A_ATTR_RET_LO, 8'hff, k ? 8'h00 : 8'(k + 1));
            rd(`PCRB_A_ATTR_RET_HI, 8'hff, 8'h00);
            for (int j = 0; j < 4; j++) wr(19'(`PCRB_A_MODE_OP0 + j), mbw[8*j +: 8]);
            @(posedge clk_i);
            rd(`PCRB_A_MODE_DONE, 8'h80, 8'h00);
            `CHK(mode_op_word_o, mbw)
            repeat (6) @(posedge clk_i);
            rd(`PCRB_A_MODE_DONE, 8'h81, {1'b1, 6'h00, k[0]});
        end
        wr(`PCRB_A_LOAD_CAL, 8'h20);
        wr(`PCRB_A_RELOAD, 8'h01);
        `CHK(reload_cal_o, 1'b1)
        // wrap of 5280 minus 32 for the block-code use
        wr(`PCRB_A_BITCNT_LO, 8'h00);
        wr(`PCRB_A_BITCNT_MID, 8'h48);
        wr(`PCRB_A_BITCNT_HI, 8'h01);
        wr(`PCRB_A_REFMAP_A, 8'h81);
        wr(`PCRB_A_REFMAP_B, 8'h23);
        wr(`PCRB_A_REFMAP_C, 8'h45);
        wr(`PCRB_A_TX_CLK_DP, 8'ha5);
        wr(`PCRB_A_RX_CLK_DP, 8'h5a);
        `CHK(bit_count_wrap_o, {13'd5248, 3'h0})
        `CHK(refclk_map_o, 24'h452381)
        `CHK({tx_clk_dp_o, rx_clk_dp_o}, 16'ha55a)
        complete_run();
    end
endmodule // pcrb_channel_regs_tb
bind pcrb_channel_regs pcrb_channel_regs_properties u_props (.*);
